// [core/leb_pkg.sv]
// package: register map, field positions and carrier types for the blanking control
package leb_pkg;
	localparam int LEB_DATA_W = 32;
	localparam int LEB_ADDR_W = 4;
	localparam logic [3:0] LEB_OFF_CTRL = 4'h0;
	localparam logic [3:0] LEB_OFF_STAT = 4'h4;
	localparam logic [3:0] LEB_OFF_DUR = 4'h8;
	localparam int LEB_CNT_W = 10;
	localparam logic [LEB_CNT_W-1:0] LEB_DUR_RESET = 10'h000;
	localparam logic [15:0] LEB_CTRL_RESET = 16'h0000;
	// writable bits: 15..10 and 5..0; 9..6 read as zero
	localparam logic [15:0] LEB_CTRL_MASK = 16'hfc3f;
	localparam int LEB_B_HR = 15;
	localparam int LEB_B_HF = 14;
	localparam int LEB_B_LR = 13;
	localparam int LEB_B_LF = 12;
	localparam int LEB_B_FLT = 11;
	localparam int LEB_B_CL = 10;
	localparam int LEB_B_AH = 5;
	localparam int LEB_B_AL = 4;
	localparam int LEB_B_HH = 3;
	localparam int LEB_B_HL = 2;
	localparam int LEB_B_LH = 1;
	localparam int LEB_B_LL = 0;
	localparam logic [1:0] LEB_RESP_OKAY = 2'b00;
	localparam logic [1:0] LEB_RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic high_side_pwm_output;
		logic low_side_pwm_output;
		logic aux_blank;
		logic fault_in;
		logic current_limit_in;
	} leb_sig_s;

	typedef struct packed {
		logic fault_out;
		logic current_limit_out;
		logic edge_blank;
		logic state_blank;
	} leb_out_s;
endpackage

// [core/leb_blank_cnt.sv]
// blanking counter: restarts on every trigger, active while counting
`timescale 1ns/100ps
`default_nettype none
module leb_blank_cnt import leb_pkg::*; #(
	parameter int CNT_W = LEB_CNT_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic trigger,
	input wire logic [CNT_W-1:0] duration,
	output logic active
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic active;
	} leb_cnt_s;
	leb_cnt_s st;
	leb_cnt_s next_st;

	always_comb begin
		next_st = st;
		if (trigger) begin
			next_st.cnt = duration;
			next_st.active = 1'b1;
		end else if (st.active) begin
			if (st.cnt == '0) begin
				next_st.active = 1'b0;
			end else begin
				next_st.cnt = st.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign active = st.active;
endmodule
`default_nettype wire

// [core/leb_ctrl.sv]
// leading-edge and state blanking for one pwm generator, with axi4-lite registers
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module leb_ctrl import leb_pkg::*; #(
	parameter int CNT_W = LEB_CNT_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [LEB_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [LEB_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [LEB_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [LEB_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire leb_sig_s sig_in,
	output leb_out_s sig_out
);
	typedef struct packed {
		logic [15:0] ctrl;
		logic [CNT_W-1:0] dur;
		leb_sig_s meta;
		leb_sig_s sync;
		logic hi_prev;
		logic lo_prev;
		logic aw_got;
		logic [LEB_ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [LEB_DATA_W-1:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [LEB_DATA_W-1:0] rdata;
		leb_out_s outq;
	} leb_state_s;

	leb_state_s st;
	leb_state_s next_st;
	logic trigger;
	logic edge_active;

	// ----------------------------------------------------------------
	// blanking counter
	// ----------------------------------------------------------------
	leb_blank_cnt #(.CNT_W(CNT_W)) u_cnt (
		.aclk(aclk),
		.aresetn(aresetn),
		.trigger(trigger),
		.duration(st.dur),
		.active(edge_active)
	);

	// ----------------------------------------------------------------
	// edge detection on synchronised pwm outputs
	// ----------------------------------------------------------------
	always_comb begin
		trigger = 1'b0;
		if (st.ctrl[LEB_B_HR] && st.sync.high_side_pwm_output && !st.hi_prev) begin
			trigger = 1'b1;
		end
		if (st.ctrl[LEB_B_HF] && !st.sync.high_side_pwm_output && st.hi_prev) begin
			trigger = 1'b1;
		end
		if (st.ctrl[LEB_B_LR] && st.sync.low_side_pwm_output && !st.lo_prev) begin
			trigger = 1'b1;
		end
		if (st.ctrl[LEB_B_LF] && !st.sync.low_side_pwm_output && st.lo_prev) begin
			trigger = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic state_blk;
	logic flt_blk;
	logic cl_blk;
	logic [LEB_DATA_W-1:0] wr_mask;
	logic [LEB_DATA_W-1:0] merged;
	logic wr_fire;

	always_comb begin
		next_st = st;
		state_blk = 1'b0;
		flt_blk = 1'b0;
		cl_blk = 1'b0;
		merged = '0;
		wr_fire = 1'b0;
		for (int i = 0; i < 4; i++) begin
			wr_mask[8*i +: 8] = {8{st.w_strb[i]}};
		end
		// pins pass two flip-flops; only the second stage feeds logic
		next_st.meta = sig_in;
		next_st.sync = st.meta;
		next_st.hi_prev = st.sync.high_side_pwm_output;
		next_st.lo_prev = st.sync.low_side_pwm_output;

		state_blk = state_blk | (st.ctrl[LEB_B_AH] & st.sync.aux_blank);
		state_blk = state_blk | (st.ctrl[LEB_B_AL] & ~st.sync.aux_blank);
		state_blk = state_blk | (st.ctrl[LEB_B_HH] & st.sync.high_side_pwm_output);
		state_blk = state_blk | (st.ctrl[LEB_B_HL] & ~st.sync.high_side_pwm_output);
		state_blk = state_blk | (st.ctrl[LEB_B_LH] & st.sync.low_side_pwm_output);
		state_blk = state_blk | (st.ctrl[LEB_B_LL] & ~st.sync.low_side_pwm_output);
		flt_blk = (st.ctrl[LEB_B_FLT] & edge_active) | state_blk;
		cl_blk = (st.ctrl[LEB_B_CL] & edge_active) | state_blk;
		next_st.outq.fault_out = st.sync.fault_in & ~flt_blk;
		next_st.outq.current_limit_out = st.sync.current_limit_in & ~cl_blk;
		next_st.outq.edge_blank = edge_active;
		next_st.outq.state_blank = state_blk;

		// write channel: address and data accepted in either order
		if (s_axi_awvalid && !st.aw_got) begin
			next_st.aw_got = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.w_got) begin
			next_st.w_got = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (st.aw_got && st.w_got && !st.bvalid) begin
			wr_fire = 1'b1;
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = LEB_RESP_OKAY;
			if (st.aw_addr == LEB_OFF_CTRL) begin
				merged = ({16'h0000, st.ctrl} & ~wr_mask) | (st.w_data & wr_mask);
				next_st.ctrl = merged[15:0] & LEB_CTRL_MASK;
			end else if (st.aw_addr == LEB_OFF_DUR) begin
				merged = ({{(LEB_DATA_W-CNT_W){1'b0}}, st.dur} & ~wr_mask) |
					(st.w_data & wr_mask);
				next_st.dur = merged[CNT_W-1:0];
			end else if (st.aw_addr == LEB_OFF_STAT) begin
				next_st.bresp = LEB_RESP_OKAY;
			end else begin
				next_st.bresp = LEB_RESP_SLVERR;
			end
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end

		// read channel
		if (s_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = LEB_RESP_OKAY;
			if (s_axi_araddr == LEB_OFF_CTRL) begin
				next_st.rdata = {16'h0000, st.ctrl};
			end else if (s_axi_araddr == LEB_OFF_STAT) begin
				next_st.rdata = {28'h0000000, st.outq.edge_blank, st.outq.state_blank,
					flt_blk, cl_blk};
			end else if (s_axi_araddr == LEB_OFF_DUR) begin
				next_st.rdata = {{(LEB_DATA_W-CNT_W){1'b0}}, st.dur};
			end else begin
				next_st.rdata = '0;
				next_st.rresp = LEB_RESP_SLVERR;
			end
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.ctrl <= LEB_CTRL_RESET;
			st.dur <= LEB_DUR_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = !st.aw_got;
	assign s_axi_wready = !st.w_got;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rresp = st.rresp;
	assign s_axi_rdata = st.rdata;
	assign sig_out = st.outq;
endmodule
`default_nettype wire

// [dv/leb_properties.sv]
// checker: bus handshake and blanking output properties of leb_ctrl
`timescale 1ns/100ps
`default_nettype none
module leb_properties import leb_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire leb_sig_s sig_in,
	input wire leb_out_s sig_out
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// runs longer than the sync and output register delay
	sequence flt_low_s;
		!sig_in.fault_in [*6];
	endsequence
	sequence flt_high_s;
		sig_in.fault_in [*7];
	endsequence
	sequence quiet_s;
		(!sig_out.state_blank && !sig_out.edge_blank) [*2];
	endsequence
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready while busy");
	read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid stuck");
	reset_quiet_a: assert property ($rose(aresetn) |-> sig_out == '0)
		else $error("outputs after reset");
	state_mask_a: assert property (sig_out.state_blank |->
		!sig_out.fault_out && !sig_out.current_limit_out) else $error("state blank leaked");
	fault_low_a: assert property (flt_low_s |-> !sig_out.fault_out)
		else $error("fault without input");
	fault_pass_a: assert property (flt_high_s ##0 quiet_s |-> sig_out.fault_out)
		else $error("fault lost");
endmodule
bind leb_ctrl leb_properties u_props(
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.sig_in(sig_in),
	.sig_out(sig_out)
);
`default_nettype wire

// [dv/testbench.sv]
// bench for leb_ctrl: registers, state and edge blanking
`timescale 1ns/100ps
`default_nettype none
module testbench import leb_pkg::*;;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	leb_sig_s sig_in;
	leb_out_s sig_out;
	int bad_count, n_compared, cyc;
	leb_ctrl u_dut(
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.sig_in(sig_in),
		.sig_out(sig_out)
	);
	initial begin
		aclk = 1'h0;
		forever #50 aclk = ~aclk;
	end
	// tests need about 880 cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			wrap_up();
		end
	end
	task automatic wrap_up;
		$display("%0d compared, %0d bad", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0,
		input logic [3:0] s = 4'hf);
		logic aw_hs, w_hs, b_hs;
		logic [1:0] resp;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		b_hs = 1'h0;
		while (!b_hs) begin
			// handshakes are judged at the falling edge, where the ready outputs have settled
			@(negedge aclk);
			aw_hs = s_axi_awvalid && s_axi_awready;
			w_hs = s_axi_wvalid && s_axi_wready;
			b_hs = s_axi_bvalid && s_axi_bready;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (aw_hs) s_axi_awvalid <= 1'h0;
			if (w_hs) s_axi_wvalid <= 1'h0;
		end
		s_axi_bready <= 1'h0;
		// one idle edge so the next request never re-raises a signal just lowered
		@(posedge aclk);
		chk("bresp", 32'(resp), 32'(r));
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		logic ar_hs, r_hs;
		logic [31:0] data;
		logic [1:0] resp;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		r_hs = 1'h0;
		while (!r_hs) begin
			@(negedge aclk);
			ar_hs = s_axi_arvalid && s_axi_arready;
			r_hs = s_axi_rvalid && s_axi_rready;
			data = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
			if (ar_hs) s_axi_arvalid <= 1'h0;
		end
		s_axi_rready <= 1'h0;
		@(posedge aclk);
		chk("rdata", data, d);
		chk("rresp", 32'(resp), 32'(r));
	endtask
	task automatic see(input logic [4:0] v, input int n, input logic [3:0] e);
		logic [3:0] got;
		sig_in <= v;
		repeat (n) @(posedge aclk);
		// read half a cycle after the launching edge to stay clear of the update race
		@(negedge aclk);
		got = sig_out;
		@(posedge aclk);
		chk("sig_out", 32'(got), 32'(e));
	endtask
	task automatic t_regs;
		rd(4'h0, 32'h0);
		wr(4'h0, 32'hffffffff);
		rd(4'h0, 32'hfc3f);
		wr(4'h8, 32'h14);
		wr(4'hc, 32'h1, LEB_RESP_SLVERR);
		rd(4'hc, 32'h0, LEB_RESP_SLVERR);
		rd(4'h8, 32'h14);
		rd(4'h4, 32'h7);
		wr(4'h4, 32'h0);
		wr(4'h0, 32'h0, LEB_RESP_OKAY, 4'h1);
		rd(4'h0, 32'hfc00);
		$display("regs done");
	endtask
	task automatic t_state;
		logic [4:0] m;
		for (int b = 0; b < 6; b++) begin
			m = (b < 2) ? 5'h08 : (b < 4) ? 5'h10 : 5'h04;
			wr(4'h0, 32'(1 << b));
			see(b[0] ? 5'h03 | m : 5'h03, 8, 4'h1);
			see(b[0] ? 5'h03 : 5'h03 | m, 8, 4'hc);
		end
		$display("state done");
	endtask
	task automatic t_edge;
		logic [4:0] m;
		for (int b = 12; b < 16; b++) begin
			m = (b < 14) ? 5'h08 : 5'h10;
			for (int en = 0; en < 2; en++) begin
				wr(4'h0, 32'(en << b) | 32'h800);
				see(b[0] ? 5'h03 : 5'h03 | m, 30, 4'hc);
				see(b[0] ? 5'h03 | m : 5'h03, 8, en ? 4'h6 : 4'hc);
				see(b[0] ? 5'h03 | m : 5'h03, 30, 4'hc);
			end
		end
		$display("edge done");
	endtask
	task automatic t_retrig;
		wr(4'h0, 32'hc400);
		see(5'h03, 30, 4'hc);
		see(5'h13, 15, 4'ha);
		see(5'h03, 18, 4'ha);
		see(5'h03, 20, 4'hc);
		see(5'h00, 10, 4'h0);
		$display("retrig done");
	endtask
	initial begin
		aresetn = 1'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		sig_in = 5'h03;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_state();
		t_edge();
		t_retrig();
		wrap_up();
	end
endmodule
`default_nettype wire
